// ### verilog/lmsc_pkg.sv
// shared constants and types for the led matrix scan and stack configuration block
package lmsc_pkg;
   localparam int          LMSC_LINES       = 16;
   localparam int          LMSC_LINE_W      = 4;
   localparam int          LMSC_MAX_DEV     = 4;
   localparam int          LMSC_FAULT_W     = 48;
   // register byte offsets
   localparam logic [11:0] LMSC_OFS_CFG     = 12'h000;
   localparam logic [11:0] LMSC_OFS_GAIN    = 12'h004;
   localparam logic [11:0] LMSC_OFS_TRIM    = 12'h008;
   localparam logic [11:0] LMSC_OFS_SCAN    = 12'h00C;
   localparam logic [11:0] LMSC_OFS_OPEN    = 12'h010;
   localparam logic [11:0] LMSC_OFS_WSHORT  = 12'h014;
   localparam logic [11:0] LMSC_OFS_SHORT   = 12'h018;
   localparam logic [11:0] LMSC_OFS_IRQ_ST  = 12'h01C;
   localparam logic [11:0] LMSC_OFS_IRQ_MSK = 12'h020;
   localparam logic [11:0] LMSC_OFS_FSEL    = 12'h024;
   // field positions in the configuration word
   localparam int          LMSC_CFG_SIZE_LSB = 0;
   localparam int          LMSC_CFG_REV_BIT  = 4;
   localparam int          LMSC_CFG_POS_LSB  = 8;
   localparam int          LMSC_CFG_RUN_BIT  = 12;
   localparam int          LMSC_CFG_LAST_LSB = 16;
   // values after reset
   localparam logic [2:0]  LMSC_GAIN_RST    = 3'h3;
   localparam logic [7:0]  LMSC_TRIM_RST    = 8'h7F;
   localparam logic [3:0]  LMSC_LAST_RST    = 4'hF;
   localparam logic [2:0]  LMSC_SIZE_RST    = 3'h0;
   // line step length in clock cycles
   localparam int          LMSC_STEP_CYC    = 64;
   // interrupt bits
   localparam int          LMSC_IRQ_OPEN    = 0;
   localparam int          LMSC_IRQ_WSHORT  = 1;
   localparam int          LMSC_IRQ_SHORT   = 2;
   localparam int          LMSC_IRQ_FRAME   = 3;
   localparam int          LMSC_IRQ_W       = 4;

   typedef enum logic [2:0] {
      LMSC_SZ_INDEP   = 3'b000,
      LMSC_SZ_TWO     = 3'b001,
      LMSC_SZ_THREE_A = 3'b010,
      LMSC_SZ_THREE_B = 3'b011,
      LMSC_SZ_THREE_C = 3'b100,
      LMSC_SZ_THREE_D = 3'b101,
      LMSC_SZ_FOUR    = 3'b110
   } lmsc_size_t;

   typedef struct packed {
      logic [7:0] red_group_trim;
      logic [7:0] green_group_trim;
      logic [7:0] blue_group_trim;
   } lmsc_trim_t;

   typedef struct packed {
      logic [2:0]  global_gain_code;
      lmsc_trim_t  trim;
   } lmsc_current_t;

   typedef struct packed {
      logic [LMSC_FAULT_W-1:0] open_flags;
      logic [LMSC_FAULT_W-1:0] wshort_flags;
      logic [LMSC_FAULT_W-1:0] short_flags;
   } lmsc_fault_t;
endpackage : lmsc_pkg

// ### verilog/lmsc_order.sv
// decode of matrix size select into device count and scan order slot
`timescale 1ns/1ps
module lmsc_order
   import lmsc_pkg::*;
(
   input  wire logic [2:0] matrix_size_select,
   input  wire logic [1:0] device_position,
   output logic            stacked,
   output logic [2:0]      device_count,
   output logic [1:0]      scan_slot
);
   always_comb begin
      stacked      = 1'b1;
      device_count = 3'h1;
      scan_slot    = 2'h0;
      case (matrix_size_select)
         LMSC_SZ_INDEP: begin
            stacked      = 1'b0;
            device_count = 3'h1;
            scan_slot    = 2'h0;
         end
         LMSC_SZ_TWO: begin
            device_count = 3'h2;
            scan_slot    = device_position;
         end
         LMSC_SZ_THREE_A, LMSC_SZ_THREE_C: begin
            device_count = 3'h3;
            scan_slot    = device_position;
         end
         LMSC_SZ_THREE_B, LMSC_SZ_THREE_D: begin
            // order 1,3,2: device 3 scans second, device 2 third
            device_count = 3'h3;
            case (device_position)
               2'h1:    scan_slot = 2'h2;
               2'h2:    scan_slot = 2'h1;
               default: scan_slot = device_position;
            endcase
         end
         LMSC_SZ_FOUR: begin
            device_count = 3'h4;
            scan_slot    = device_position;
         end
         default: begin
            stacked      = 1'b0;
            device_count = 3'h1;
            scan_slot    = 2'h0;
         end
      endcase
   end
endmodule : lmsc_order

// ### verilog/lmsc_fault_mem.sv
// small registered memory holding per-line fault words
`timescale 1ns/1ps
module lmsc_fault_mem
   import lmsc_pkg::*;
#(
   parameter int WIDTH = 3 * LMSC_FAULT_W,
   parameter int DEPTH = LMSC_LINES
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   initial begin
      if (DEPTH < 2) $error("lmsc_fault_mem depth too small");
   end

   // cleared at reset so the or-merge never starts from unknown bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (wr_en) begin
         mem_reg[wr_addr] <= mem_reg[wr_addr] | wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule : lmsc_fault_mem

// ### verilog/lmsc_top.sv
// scan, stacking and current configuration logic with apb register file
`timescale 1ns/1ps
module lmsc_top
   import lmsc_pkg::*;
#(
   parameter int STEP_CYCLES = LMSC_STEP_CYC
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    fault_valid,
   input  wire logic [LMSC_FAULT_W-1:0] fault_open,
   input  wire logic [LMSC_FAULT_W-1:0] fault_wshort,
   input  wire logic [LMSC_FAULT_W-1:0] fault_short,
   output logic      [LMSC_LINES-1:0]   line_switch,
   output logic                         data_sections_ac,
   output lmsc_current_t                current_cfg,
   output logic                         irq
);
   initial begin
      if (STEP_CYCLES < 2) $error("lmsc_top step length too short");
   end

   logic [2:0]             size_reg;
   logic                   rev_reg;
   logic [1:0]             pos_reg;
   logic                   run_reg;
   logic [LMSC_LINE_W-1:0] last_reg;
   logic [2:0]             gain_reg;
   lmsc_trim_t             trim_reg;
   logic [LMSC_IRQ_W-1:0]  irq_st_reg;
   logic [LMSC_IRQ_W-1:0]  irq_msk_reg;
   logic [LMSC_LINE_W-1:0] fsel_reg;
   logic [1:0]             slot_reg;
   logic [LMSC_LINE_W-1:0] step_reg;
   logic [$clog2(STEP_CYCLES)-1:0] tick_reg;
   logic                   step_en;
   logic                   stacked;
   logic [2:0]             dev_count;
   logic [1:0]             my_slot;
   logic                   wr_acc;
   logic                   rd_acc;
   logic                   addr_ok;
   logic [31:0]            wmask;
   logic [31:0]            rd_next;
   logic [3*LMSC_FAULT_W-1:0] fault_rd;
   logic [LMSC_IRQ_W-1:0]  irq_events;
   logic                   frame_end;

   function automatic logic known_addr(input logic [11:0] a);
      case (a)
         LMSC_OFS_CFG, LMSC_OFS_GAIN, LMSC_OFS_TRIM, LMSC_OFS_SCAN,
         LMSC_OFS_OPEN, LMSC_OFS_WSHORT, LMSC_OFS_SHORT,
         LMSC_OFS_IRQ_ST, LMSC_OFS_IRQ_MSK, LMSC_OFS_FSEL: known_addr = 1'b1;
         default: known_addr = 1'b0;
      endcase
   endfunction : known_addr

   // zero-wait-state slave: answers in the access cycle itself
   assign addr_ok = known_addr(paddr);
   assign wr_acc  = psel & penable & pwrite & addr_ok;
   assign rd_acc  = psel & ~penable & ~pwrite;

   always_comb begin
      wmask = '0;
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   // pready and pslverr registered in setup so they stand for the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~known_addr(paddr);
      end
   end

   lmsc_order u_order (
      .matrix_size_select (size_reg),
      .device_position    (pos_reg),
      .stacked            (stacked),
      .device_count       (dev_count),
      .scan_slot          (my_slot)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_reg <= LMSC_SIZE_RST;
         rev_reg  <= 1'b0;
         pos_reg  <= 2'h0;
         run_reg  <= 1'b0;
         last_reg <= LMSC_LAST_RST;
      end else if (wr_acc && paddr == LMSC_OFS_CFG) begin
         if (pstrb[0]) begin
            size_reg <= pwdata[LMSC_CFG_SIZE_LSB +: 3];
            rev_reg  <= pwdata[LMSC_CFG_REV_BIT];
         end
         if (pstrb[1]) begin
            pos_reg  <= pwdata[LMSC_CFG_POS_LSB +: 2];
            run_reg  <= pwdata[LMSC_CFG_RUN_BIT];
         end
         if (pstrb[2]) begin
            // software sets the last used step, leaving the top switches idle, or the bottom ones when stacked and reversed
            last_reg <= pwdata[LMSC_CFG_LAST_LSB +: LMSC_LINE_W];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_reg <= LMSC_GAIN_RST;
      end else if (wr_acc && paddr == LMSC_OFS_GAIN && pstrb[0]) begin
         gain_reg <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_reg <= '{LMSC_TRIM_RST, LMSC_TRIM_RST, LMSC_TRIM_RST};
      end else if (wr_acc && paddr == LMSC_OFS_TRIM) begin
         if (pstrb[0]) trim_reg.blue_group_trim  <= pwdata[7:0];
         if (pstrb[1]) trim_reg.green_group_trim <= pwdata[15:8];
         if (pstrb[2]) trim_reg.red_group_trim   <= pwdata[23:16];
      end
   end

   // trim is applied on top of the common gain by the analog stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_cfg <= '{LMSC_GAIN_RST, '{LMSC_TRIM_RST, LMSC_TRIM_RST, LMSC_TRIM_RST}};
      end else begin
         current_cfg <= '{gain_reg, trim_reg};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_reg <= '0;
      end else if (wr_acc && paddr == LMSC_OFS_FSEL && pstrb[0]) begin
         fsel_reg <= pwdata[LMSC_LINE_W-1:0];
      end
   end

   // step enable divider
   assign step_en = run_reg && (tick_reg == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= '0;
      end else if (!run_reg || step_en) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 1'b1;
      end
   end

   // every chained device runs the same slot/step counters, so all agree on
   // which one drives; a device only drives while the slot is its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_reg <= '0;
         slot_reg <= 2'h0;
      end else if (!run_reg) begin
         step_reg <= '0;
         slot_reg <= 2'h0;
      end else if (step_en) begin
         if (step_reg >= last_reg) begin
            step_reg <= '0;
            if (!stacked || slot_reg == 2'(dev_count - 3'h1)) begin
               slot_reg <= 2'h0;
            end else begin
               slot_reg <= slot_reg + 2'h1;
            end
         end else begin
            step_reg <= step_reg + 1'b1;
         end
      end
   end

   assign frame_end = step_en && (step_reg >= last_reg) &&
                      (!stacked || slot_reg == 2'(dev_count - 3'h1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_switch <= '0;
      end else if (!run_reg || (stacked && slot_reg != my_slot)) begin
         line_switch <= '0;
      end else if (stacked && rev_reg) begin
         line_switch <= LMSC_LINES'(1) << (4'(LMSC_LINES - 1) - step_reg);
      end else begin
         line_switch <= LMSC_LINES'(1) << step_reg;
      end
   end

   // in the two-device stack the first device holds A and C, the second B and D
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_sections_ac <= 1'b1;
      end else begin
         data_sections_ac <= (size_reg != LMSC_SZ_TWO) || (pos_reg == 2'h0);
      end
   end

   // fault words are or-merged per active line so a short glitch is kept
   lmsc_fault_mem #(
      .WIDTH (3 * LMSC_FAULT_W),
      .DEPTH (LMSC_LINES)
   ) u_fault_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (fault_valid),
      .wr_addr (step_reg),
      .wr_data ({fault_open, fault_wshort, fault_short}),
      .rd_addr (fsel_reg),
      .rd_data (fault_rd)
   );

   assign irq_events = {frame_end,
                        fault_valid & (|fault_short),
                        fault_valid & (|fault_wshort),
                        fault_valid & (|fault_open)};

   // set wins over a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_reg <= '0;
      end else if (wr_acc && paddr == LMSC_OFS_IRQ_ST && pstrb[0]) begin
         irq_st_reg <= (irq_st_reg & ~pwdata[LMSC_IRQ_W-1:0]) | irq_events;
      end else begin
         irq_st_reg <= irq_st_reg | irq_events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_msk_reg <= '0;
      end else if (wr_acc && paddr == LMSC_OFS_IRQ_MSK && pstrb[0]) begin
         irq_msk_reg <= pwdata[LMSC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st_reg & irq_msk_reg);
      end
   end

   // fault words come from the registered memory; fsel must settle a cycle early
   always_comb begin
      rd_next = '0;
      case (paddr)
         LMSC_OFS_CFG:     rd_next = 32'({last_reg, 3'h0, run_reg, 2'h0, pos_reg, 3'h0, rev_reg, 1'b0, size_reg});
         LMSC_OFS_GAIN:    rd_next = 32'(gain_reg);
         LMSC_OFS_TRIM:    rd_next = 32'(trim_reg);
         LMSC_OFS_SCAN:    rd_next = 32'({slot_reg, my_slot, stacked, step_reg});
         LMSC_OFS_OPEN:    rd_next = fault_rd[2*LMSC_FAULT_W +: 32];
         LMSC_OFS_WSHORT:  rd_next = fault_rd[LMSC_FAULT_W +: 32];
         LMSC_OFS_SHORT:   rd_next = fault_rd[0 +: 32];
         LMSC_OFS_IRQ_ST:  rd_next = 32'(irq_st_reg);
         LMSC_OFS_IRQ_MSK: rd_next = 32'(irq_msk_reg);
         LMSC_OFS_FSEL:    rd_next = 32'(fsel_reg);
         default:          rd_next = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_acc) begin
         prdata <= rd_next & 32'hFFFFFFFF & ~(wmask & 32'h00000000);
      end
   end
endmodule : lmsc_top

// ### tb/lmsc_asserts.sv
// concurrent checks on the ports of the scan and current configuration block
`timescale 1ns/1ps
module lmsc_asserts
   import lmsc_pkg::*;
#(
   parameter int STEP_CYCLES = LMSC_STEP_CYC
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    fault_valid,
   input wire logic [LMSC_FAULT_W-1:0] fault_open,
   input wire logic [LMSC_FAULT_W-1:0] fault_wshort,
   input wire logic [LMSC_FAULT_W-1:0] fault_short,
   input wire logic [LMSC_LINES-1:0]   line_switch,
   input wire logic                    data_sections_ac,
   input wire lmsc_current_t           current_cfg,
   input wire logic                    irq
);
   logic [15:0] ls_q;
   logic [7:0]  cnt_q;
   logic [2:0]  cfg_q;
   logic        vld_q;
   logic        acc;
   logic        cw;
   logic        chg;
   assign acc = psel && penable && pwrite && pready;
   assign cw  = acc && paddr == LMSC_OFS_CFG;
   assign chg = line_switch != ls_q;
   // step timing is only trusted after one clean step boundary since the last config write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_q  <= '0;
         cnt_q <= '0;
         cfg_q <= '0;
         vld_q <= 1'b0;
      end else begin
         ls_q  <= line_switch;
         cnt_q <= chg ? 8'h00 : cnt_q + 8'h01;
         cfg_q <= {cfg_q[1:0], cw};
         vld_q <= cw ? 1'b0 : (chg ? 1'b1 : vld_q);
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_line_onehot: assert property ($onehot0(line_switch))
      else $error("more than one line switch active");
   a_step_period: assert property (chg && ls_q != 16'h0 && line_switch != 16'h0 && vld_q && cfg_q == 3'h0
      |-> cnt_q == STEP_CYCLES - 1) else $error("line step length wrong");
   a_gain_takes: assert property (acc && paddr == LMSC_OFS_GAIN && pstrb[0]
      |-> ##2 current_cfg.global_gain_code == $past(pwdata[2:0], 2)) else $error("gain not applied");
   a_trim_takes: assert property (acc && paddr == LMSC_OFS_TRIM && pstrb == 4'hF
      |-> ##2 current_cfg.trim == $past(pwdata[23:0], 2)) else $error("trim not applied");
   a_cfg_stable: assert property (!acc && !$past(acc) |=> $stable(current_cfg))
      else $error("current setting moved without a write");
   a_sections_cause: assert property ($changed(data_sections_ac) |-> cfg_q != 3'h0)
      else $error("section ownership moved without a config write");
   c_irq: cover property (irq);
   c_err: cover property (pslverr);
   c_rev: cover property (line_switch[15]);
endmodule : lmsc_asserts

bind lmsc_top lmsc_asserts #(.STEP_CYCLES(STEP_CYCLES)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fault_valid(fault_valid), .fault_open(fault_open),
   .fault_wshort(fault_wshort), .fault_short(fault_short), .line_switch(line_switch),
   .data_sections_ac(data_sections_ac), .current_cfg(current_cfg), .irq(irq)
);

// ### tb/lmsc_fault_src.sv
// fault source standing in for the led fault detectors
`timescale 1ns/1ps
module lmsc_fault_src
   import lmsc_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    fire,
   input  wire logic [1:0]              kind,
   output logic                         fault_valid,
   output logic      [LMSC_FAULT_W-1:0] fault_open,
   output logic      [LMSC_FAULT_W-1:0] fault_wshort,
   output logic      [LMSC_FAULT_W-1:0] fault_short
);
   logic [LMSC_FAULT_W-1:0] pat;
   initial begin
      fault_valid  = 1'b0;
      fault_open   = '0;
      fault_wshort = '0;
      fault_short  = '0;
   end
   // flags churn outside valid cycles so stale data cannot pass for a fault
   always @(posedge pclk) begin
      pat = 48'({$urandom, $urandom}) | 48'h1;
      fault_valid  <= fire;
      fault_open   <= fire ? ((kind == 2'h0) ? pat : '0) : ~fault_open;
      fault_wshort <= fire ? ((kind == 2'h1) ? pat : '0) : ~fault_wshort;
      fault_short  <= fire ? ((kind == 2'h2) ? pat : '0) : ~fault_short;
   end
endmodule : lmsc_fault_src

// ### tb/lmsc_top_tb.sv
// self-checking bench for the scan, stack and current configuration block
`timescale 1ns/1ps
module lmsc_top_tb;
   import lmsc_pkg::*;
   localparam int STEP = 4;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, cap = 0;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0, prdata, rd;
   logic [3:0]    pstrb = 4'hF;
   logic [1:0]    kind = '0;
   logic          pready, pslverr, fv, dsec, irq, er;
   logic [47:0]   fo, fw, fs;
   logic [15:0]   line_switch, first, last_ls;
   logic [15:0]   seq[$];
   logic [47:0]   mf[3] = '{default: '0};
   lmsc_current_t ccfg;
   int            error_cnt = 0, checks = 0, cyc = 0;
   lmsc_top #(.STEP_CYCLES(STEP)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fault_valid(fv), .fault_open(fo), .fault_wshort(fw),
      .fault_short(fs), .line_switch(line_switch), .data_sections_ac(dsec),
      .current_cfg(ccfg), .irq(irq));
   lmsc_fault_src i_src (.pclk(pclk), .fire(fire), .kind(kind), .fault_valid(fv),
      .fault_open(fo), .fault_wshort(fw), .fault_short(fs));
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // reference copy of the or-merged fault words of line 0, taken from the source
   always @(posedge pclk) begin
      if (fv === 1'b1) begin
         mf[0] <= mf[0] | fo;
         mf[1] <= mf[1] | fw;
         mf[2] <= mf[2] | fs;
      end
   end
   // only distinct active switches are kept, so the order is checked free of timing
   always @(posedge pclk) begin
      if (cap && line_switch !== 16'h0 && line_switch !== last_ls && (seq.size() > 0 || line_switch === first)) begin
         seq.push_back(line_switch);
         last_ls = line_switch;
      end
   end
   task automatic wrap_up();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   function automatic logic [31:0] cfgw(int sz, int rev, int pos, int run, int last);
      return 32'(sz) | (32'(rev) << 4) | (32'(pos) << 8) | (32'(run) << 12) | (32'(last) << 16);
   endfunction : cfgw
   task automatic scan(input string nm, input logic [31:0] w, input int rev, input int n);
      cap = 0;
      seq.delete();
      last_ls = 16'h0;
      first = rev ? 16'h8000 : 16'h0001;
      xfer(1'b1, LMSC_OFS_CFG, w & ~32'h1000);
      xfer(1'b1, LMSC_OFS_CFG, w);
      cap = 1;
      while (seq.size() < 20) @(posedge pclk);
      cap = 0;
      for (int i = 0; i < 20; i++) check(nm, 32'(seq[i]), rev ? 32'h8000 >> (i % n) : 32'h1 << (i % n));
      $display("test %s done", nm);
   endtask : scan
   initial begin
      int slot;
      logic [23:0] t;
      void'($urandom(49));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("cfg reset", 32'(ccfg), {5'h0, 3'h3, 24'h7F7F7F});
      check("sections reset", 32'(dsec), 32'h1);
      xfer(1'b0, LMSC_OFS_GAIN, 32'h0);
      check("gain reset", rd, 32'h3);
      xfer(1'b0, LMSC_OFS_TRIM, 32'h0);
      check("trim reset", rd, 32'h007F7F7F);
      $display("test reset done");
      for (int g = 0; g < 8; g++) begin
         t = 24'($urandom);
         xfer(1'b1, LMSC_OFS_GAIN, 32'(g));
         xfer(1'b1, LMSC_OFS_TRIM, 32'(t));
         xfer(1'b0, LMSC_OFS_GAIN, 32'h0);
         check("gain", rd, 32'(g));
         check("current", 32'(ccfg), {5'h0, 3'(g), t});
      end
      xfer(1'b1, 12'h0FC, 32'hFFFFFFFF);
      check("unmapped write err", 32'(er), 32'h1);
      xfer(1'b0, 12'h0FC, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("test current done");
      for (int sz = 0; sz < 7; sz++) begin
         for (int pos = 0; pos <= ((sz == 1) ? 1 : 2); pos++) begin
            xfer(1'b1, LMSC_OFS_CFG, cfgw(sz, 0, pos, 0, 15));
            xfer(1'b0, LMSC_OFS_SCAN, 32'h0);
            slot = ((sz == 3 || sz == 5) && pos != 0) ? 3 - pos : pos;
            check("stacked", 32'(rd[4]), 32'(sz != 0));
            if (sz != 0) check("slot", 32'(rd[6:5]), 32'(slot));
            if (sz < 2) check("sections", 32'(dsec), 32'(sz == 0 || pos == 0));
         end
      end
      $display("test decode done");
      xfer(1'b1, LMSC_OFS_IRQ_MSK, 32'h0);
      for (int k = 0; k < 3; k++) begin
         xfer(1'b1, LMSC_OFS_IRQ_ST, 32'hF);
         kind <= 2'(k);
         fire <= 1'b1;
         @(posedge pclk);
         fire <= 1'b0;
         repeat (2) @(posedge pclk);
         xfer(1'b0, LMSC_OFS_IRQ_ST, 32'h0);
         check("status", rd & 32'h7, 32'h1 << k);
         xfer(1'b0, LMSC_OFS_OPEN + 12'(4 * k), 32'h0);
         check("fault word", rd, mf[k][31:0]);
         check("irq masked", 32'(irq), 32'h0);
         xfer(1'b1, LMSC_OFS_IRQ_MSK, 32'h1 << k);
         @(posedge pclk);
         check("irq", 32'(irq), 32'h1);
         xfer(1'b1, LMSC_OFS_IRQ_ST, 32'h1 << k);
         @(posedge pclk);
         check("irq cleared", 32'(irq), 32'h0);
         xfer(1'b1, LMSC_OFS_IRQ_MSK, 32'h0);
      end
      $display("test faults done");
      scan("independent 14 lines", cfgw(0, 0, 0, 1, 13), 0, 14);
      scan("stack first", cfgw(1, 0, 0, 1, 15), 0, 16);
      scan("stack second reversed", cfgw(1, 1, 1, 1, 13), 1, 14);
      xfer(1'b0, LMSC_OFS_IRQ_ST, 32'h0);
      check("frame end", 32'(rd[3]), 32'h1);
      wrap_up();
   end
endmodule : lmsc_top_tb
